// ==== verilog/low_power_mode_controller.sv ====
// low power mode controller: run, wait, low power run/wait and the two stops
// assumes synchronous inputs on clk_i, a classic wishbone master and a core
// that pulses wait_exec_i / stop_exec_i once per executed instruction
`timescale 1ns/1ns
module low_power_mode_controller
  import lpm_pkg::*;
(
  input  wire logic              clk_i,           // 25 MHz system clock
  input  wire logic              rst_n_i,         // synchronous power-on reset
  input  wire logic              wb_cyc_i,        // wishbone cycle
  input  wire logic              wb_stb_i,        // wishbone strobe
  input  wire logic              wb_we_i,         // wishbone write enable
  input  wire logic [3:0]        wb_sel_i,        // wishbone byte selects
  input  wire logic [ADDR_W-1:0] wb_adr_i,        // wishbone byte address
  input  wire logic [31:0]       wb_dat_i,        // wishbone write data
  output logic      [31:0]       wb_dat_o,        // wishbone read data
  output logic                   wb_ack_o,        // wishbone acknowledge
  input  wire logic              wait_exec_i,     // wait instruction executed
  input  wire logic              stop_exec_i,     // stop instruction executed
  input  wire wake_t             wake_i,          // wake and debug events
  input  wire logic [PIN_W-1:0]  pin_ctrl_i,      // live pin control signals
  output logic      [PIN_W-1:0]  pin_ctrl_o,      // pin control to pads
  output logic                   pin_latched_o,   // pad controls are frozen
  output logic                   display_drive_o, // display drivers active
  output clk_en_t                clk_en_o,        // clock enables
  output reg_state_t             regulator_o,     // regulator state
  output logic                   reset_vector_o,  // pulse: take reset vector
  output logic                   irq_vector_o,    // pulse: service interrupt
  output logic                   illegal_rst_o,   // pulse: illegal opcode reset
  output logic                   module_rst_o,    // pulse: reset other modules
  output logic                   debug_err_o,     // pulse: stop-or-wait error
  output logic                   debug_wake_o,    // pulse: enter debug mode
  output mode_t                  mode_o           // current mode
);

  mode_t            mode_reg, mode_next;
  logic             lpr_reg, low_power_run_status_reg, wui_reg, powerdown_control_reg, powerdown_wake_flag_reg;
  logic             lowvolt_detect_enable_reg, lowvolt_detect_in_stop_enable_reg, stop_instruction_enable_reg, debug_mode_enable_reg;
  logic             wui_entry_reg, from_lp_reg, stop_full_reg, stop_dbg_reg;
  logic             rst_pin_prev_reg, ack_reg;
  logic [31:0]      rdata_reg;
  logic [PIN_W-1:0] pin_hold_reg, pin_out_reg;
  logic             rst_out_reg, irq_out_reg, ill_out_reg, mrst_out_reg;
  logic             err_out_reg, dwake_out_reg;

  // stop kind selection, used by both run modes
  function automatic stop_sel_t stop_kind(input logic stop_instruction_enable, input logic debug_mode_enable,
                                          input logic lowvolt_detect_enable, input logic lowvolt_detect_in_stop_enable,
                                          input logic powerdown_control);
    if (!stop_instruction_enable)
      return SEL_ILLEGAL;
    else if (debug_mode_enable || (lowvolt_detect_enable && lowvolt_detect_in_stop_enable) || !powerdown_control)
      return SEL_LIGHT;
    else
      return SEL_PPD;
  endfunction

  // bus decode: the write lands on the edge where the master sees ack
  wire bus_req  = wb_cyc_i & wb_stb_i;
  wire wr_take  = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
  wire wr_one   = wr_take & (wb_adr_i == OFS_CTRL_ONE);
  wire wr_two   = wr_take & (wb_adr_i == OFS_CTRL_TWO);
  wire wr_opt   = wr_take & (wb_adr_i == OFS_SYS_OPT);
  wire wr_dbg   = wr_take & (wb_adr_i == OFS_DBG_CTRL);

  // interlock against current and same-write values
  // a request that already stands is kept; only a fresh set gives way
  wire lpr_set_ok  = wb_dat_i[BIT_LPR] & ~powerdown_control_reg & (~wb_dat_i[BIT_POWERDOWN_CONTROL] | lpr_reg);
  wire powerdown_control_set_ok = wb_dat_i[BIT_POWERDOWN_CONTROL] & ~lpr_reg;
  wire ack_write   = wr_two & wb_dat_i[BIT_POWERDOWN_ACKNOWLEDGE];

  // mode decode
  wire in_stop   = (mode_reg == MODE_LIGHT) | (mode_reg == MODE_PPD);
  wire in_wait   = (mode_reg == MODE_WAIT) | (mode_reg == MODE_LOW_POWER_WAIT_MODE);
  wire lp_mode   = (mode_reg == MODE_LOW_POWER_RUN_MODE) | (mode_reg == MODE_LOW_POWER_WAIT_MODE);
  wire in_run    = (mode_reg == MODE_RUN) | (mode_reg == MODE_LOW_POWER_RUN_MODE);
  wire rst_evt   = rst_pin_prev_reg & ~wake_i.reset_pin_n;
  wire dbg_evt   = wake_i.bg_cmd & debug_mode_enable_reg & (in_stop | in_wait);
  wire ppd_wake  = (mode_reg == MODE_PPD) &
                   (~wake_i.reset_pin_n | ~wake_i.irq_pin_n | wake_i.tod_irq);
  wire stop_go   = in_run & stop_exec_i & ~rst_evt;
  wire stop_ill  = stop_go & (stop_kind(stop_instruction_enable_reg, debug_mode_enable_reg, lowvolt_detect_enable_reg,
                                        lowvolt_detect_in_stop_enable_reg, powerdown_control_reg) == SEL_ILLEGAL);
  wire any_rst   = rst_evt | stop_ill;
  wire irq_wake  = wake_i.irq & (in_wait | mode_reg == MODE_LIGHT) & ~any_rst & ~dbg_evt;
  wire lp_target = wui_entry_reg ? 1'b0 : 1'b1; // low power return wanted
  // wake bit honoured on interrupt in low power run itself
  wire low_power_run_mode_wui = (mode_reg == MODE_LOW_POWER_RUN_MODE) & wake_i.irq & wui_reg;

  // next mode
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_RUN: begin
        if (stop_go && !stop_ill)
          mode_next = (stop_kind(stop_instruction_enable_reg, debug_mode_enable_reg, lowvolt_detect_enable_reg, lowvolt_detect_in_stop_enable_reg, powerdown_control_reg)
                       == SEL_PPD) ? MODE_PPD : MODE_LIGHT;
        else if (wait_exec_i)
          mode_next = MODE_WAIT;
        else if (lpr_reg)
          mode_next = MODE_LOW_POWER_RUN_MODE;
      end
      MODE_LOW_POWER_RUN_MODE: begin
        if (stop_go && !stop_ill)
          mode_next = MODE_LIGHT;
        else if (wait_exec_i)
          mode_next = MODE_LOW_POWER_WAIT_MODE;
        else if (!lpr_reg || low_power_run_mode_wui)
          mode_next = MODE_RUN;
      end
      MODE_WAIT: begin
        if (irq_wake || dbg_evt)
          mode_next = MODE_RUN;
      end
      MODE_LOW_POWER_WAIT_MODE: begin
        if (irq_wake)
          mode_next = lp_target ? MODE_LOW_POWER_RUN_MODE : MODE_RUN;
        else if (dbg_evt)
          mode_next = MODE_RUN;
      end
      MODE_LIGHT: begin
        if (irq_wake)
          mode_next = (from_lp_reg && lp_target) ? MODE_LOW_POWER_RUN_MODE : MODE_RUN;
        else if (dbg_evt)
          mode_next = MODE_RUN;
      end
      MODE_PPD: begin
        if (ppd_wake)
          mode_next = MODE_RUN;
      end
      default: mode_next = MODE_RUN;
    endcase
    if (any_rst)
      mode_next = MODE_RUN;
  end

  // low power run request is dropped on reset or wake-bit exit
  wire lp_exit_full = (lp_mode | (mode_reg == MODE_LIGHT & from_lp_reg)) &
                      (mode_next == MODE_RUN) & ~dbg_evt;
  wire lp_clear     = any_rst | lp_exit_full | low_power_run_mode_wui;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      mode_reg <= MODE_RUN;
    else
      mode_reg <= mode_next;
  end

  // context captured at wait or stop entry; kept through light stop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wui_entry_reg <= 1'b0;
      from_lp_reg   <= 1'b0;
      stop_full_reg <= 1'b0;
      stop_dbg_reg  <= 1'b0;
    end else if (in_run && mode_next != mode_reg && mode_next != MODE_RUN) begin
      wui_entry_reg <= wui_reg;
      from_lp_reg   <= (mode_reg == MODE_LOW_POWER_RUN_MODE);
      stop_full_reg <= debug_mode_enable_reg | (lowvolt_detect_enable_reg & lowvolt_detect_in_stop_enable_reg);
      stop_dbg_reg  <= debug_mode_enable_reg;
    end
  end

  // power management registers survive partial powerdown wake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lpr_reg   <= 1'b0;
      wui_reg   <= 1'b0;
      powerdown_control_reg  <= 1'b0;
      lowvolt_detect_enable_reg  <= RST_LOWVOLT_DETECT_ENABLE;
      lowvolt_detect_in_stop_enable_reg <= RST_LOWVOLT_DETECT_IN_STOP_ENABLE;
    end else begin
      if (wr_one) begin
        lowvolt_detect_enable_reg  <= wb_dat_i[BIT_LOWVOLT_DETECT_ENABLE];
        lowvolt_detect_in_stop_enable_reg <= wb_dat_i[BIT_LOWVOLT_DETECT_IN_STOP_ENABLE];
      end
      if (wr_two) begin
        wui_reg  <= wb_dat_i[BIT_WUI];
        powerdown_control_reg <= powerdown_control_set_ok;
      end
      // software sets and clears the request
      if (lp_clear)
        lpr_reg <= 1'b0;
      else if (wr_two)
        lpr_reg <= lpr_set_ok;
    end
  end

  // status is one in low power run and wait and in light stop entered from low power run
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      low_power_run_status_reg <= 1'b0;
    else
      low_power_run_status_reg <= (mode_next == MODE_LOW_POWER_RUN_MODE) | (mode_next == MODE_LOW_POWER_WAIT_MODE) |
                  ((mode_next == MODE_LIGHT) &
                   ((mode_reg == MODE_LOW_POWER_RUN_MODE) | (in_stop & from_lp_reg)));
  end

  // module registers: cleared by any reset or powerdown wake
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || any_rst || ppd_wake) begin
      stop_instruction_enable_reg <= RST_STOP_INSTRUCTION_ENABLE;
      debug_mode_enable_reg <= RST_DEBUG_MODE_ENABLE;
    end else begin
      if (wr_opt)
        stop_instruction_enable_reg <= wb_dat_i[BIT_STOP_INSTRUCTION_ENABLE];
      if (wr_dbg)
        debug_mode_enable_reg <= wb_dat_i[BIT_DEBUG_MODE_ENABLE];
    end
  end

  // wake flag and latch held until acknowledge; the set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      powerdown_wake_flag_reg <= 1'b0;
    else if (ppd_wake)
      powerdown_wake_flag_reg <= 1'b1;
    else if (ack_write)
      powerdown_wake_flag_reg <= 1'b0;
  end

  // pin controls captured on powerdown entry
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      pin_hold_reg <= '0;
    else if (mode_next == MODE_PPD && mode_reg != MODE_PPD)
      pin_hold_reg <= pin_ctrl_i;
  end

  // latch stays closed while in partial powerdown stop or until acknowledged
  wire latched = (mode_reg == MODE_PPD) | powerdown_wake_flag_reg;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i)
      pin_out_reg <= '0;
    else
      pin_out_reg <= (latched || mode_next == MODE_PPD) ?
                     ((mode_reg == MODE_PPD || powerdown_wake_flag_reg) ? pin_hold_reg : pin_ctrl_i) :
                     pin_ctrl_i;
  end

  // event pulses toward the core and debug block
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_pin_prev_reg <= 1'b1;
      rst_out_reg      <= 1'b0;
      irq_out_reg      <= 1'b0;
      ill_out_reg      <= 1'b0;
      mrst_out_reg     <= 1'b0;
      err_out_reg      <= 1'b0;
      dwake_out_reg    <= 1'b0;
    end else begin
      rst_pin_prev_reg <= wake_i.reset_pin_n;
      ill_out_reg   <= stop_ill;
      rst_out_reg   <= any_rst | ppd_wake;
      mrst_out_reg  <= any_rst | ppd_wake;
      irq_out_reg   <= irq_wake | low_power_run_mode_wui;
      err_out_reg   <= wake_i.mem_stat_cmd & (in_stop | in_wait);
      dwake_out_reg <= dbg_evt;
    end
  end

  // wishbone slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= bus_req & ~ack_reg;
      rdata_reg <= '0;
      unique case (wb_adr_i)
        OFS_CTRL_ONE: begin
          rdata_reg[BIT_LOWVOLT_DETECT_ENABLE]  <= lowvolt_detect_enable_reg;
          rdata_reg[BIT_LOWVOLT_DETECT_IN_STOP_ENABLE] <= lowvolt_detect_in_stop_enable_reg;
        end
        OFS_CTRL_TWO: begin
          rdata_reg[BIT_LPR]  <= lpr_reg;
          rdata_reg[BIT_LOW_POWER_RUN_STATUS] <= low_power_run_status_reg;
          rdata_reg[BIT_WUI]  <= wui_reg;
          rdata_reg[BIT_POWERDOWN_CONTROL] <= powerdown_control_reg;
          rdata_reg[BIT_POWERDOWN_WAKE_FLAG] <= powerdown_wake_flag_reg;
        end
        OFS_SYS_OPT:   rdata_reg[BIT_STOP_INSTRUCTION_ENABLE] <= stop_instruction_enable_reg;
        OFS_DBG_CTRL:  rdata_reg[BIT_DEBUG_MODE_ENABLE] <= debug_mode_enable_reg;
        OFS_MODE_STAT: rdata_reg[MODE_W-1:0] <= mode_reg;
        default:       rdata_reg <= '0;
      endcase
    end
  end

  // output decode; clocks follow the mode register directly
  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdata_reg;
  assign mode_o          = mode_reg;
  assign pin_ctrl_o      = pin_out_reg;
  assign pin_latched_o   = latched;
  assign display_drive_o = 1'b1; // display keeps driving in every mode
  assign clk_en_o.cpu    = in_run;
  assign clk_en_o.bus    = ~in_stop;
  assign clk_en_o.debug  = debug_mode_enable_reg & (~in_stop | stop_dbg_reg);
  assign regulator_o     = (mode_reg == MODE_PPD) ? REG_PARTIAL :
                           (mode_reg == MODE_LIGHT) ?
                             (stop_full_reg ? REG_FULL : REG_STANDBY) :
                           lp_mode ? REG_STANDBY : REG_FULL;
  assign reset_vector_o  = rst_out_reg;
  assign irq_vector_o    = irq_out_reg;
  assign illegal_rst_o   = ill_out_reg;
  assign module_rst_o    = mrst_out_reg;
  assign debug_err_o     = err_out_reg;
  assign debug_wake_o    = dwake_out_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_low_power_wait_mode_entry;
    (mode_reg == MODE_LOW_POWER_RUN_MODE) && wait_exec_i && !stop_exec_i && !any_rst && lpr_reg
      |=> mode_reg == MODE_LOW_POWER_WAIT_MODE && !clk_en_o.cpu && regulator_o == REG_STANDBY;
  endproperty
  a_low_power_wait_mode_entry: assert property (p_low_power_wait_mode_entry) else $error("low_power_wait_mode entry");

  property p_wui_exit;
    (mode_reg == MODE_LOW_POWER_WAIT_MODE) && irq_wake && wui_entry_reg
      |=> mode_reg == MODE_RUN && !lpr_reg ##1 !low_power_run_status_reg;
  endproperty
  a_wui_exit: assert property (p_wui_exit) else $error("wake bit exit");

  property p_lp_return;
    (mode_reg == MODE_LOW_POWER_WAIT_MODE) && irq_wake && !wui_entry_reg |=> mode_reg == MODE_LOW_POWER_RUN_MODE;
  endproperty
  a_lp_return: assert property (p_lp_return) else $error("lp return");

  property p_reset_exit;
    rst_evt |=> mode_reg == MODE_RUN && !lpr_reg && reset_vector_o;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset exit");

  property p_illegal;
    stop_ill |=> illegal_rst_o && mode_reg == MODE_RUN && !in_stop;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal stop");

  property p_stop_clocks;
    in_stop |-> !clk_en_o.cpu && !clk_en_o.bus;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("stop clocks");

  property p_no_ppd_dbg;
    stop_go && (debug_mode_enable_reg || (lowvolt_detect_enable_reg && lowvolt_detect_in_stop_enable_reg)) |=> mode_reg != MODE_PPD;
  endproperty
  a_no_ppd_dbg: assert property (p_no_ppd_dbg) else $error("ppd substituted");

  property p_flag_hold;
    powerdown_wake_flag_reg && !ack_write |=> powerdown_wake_flag_reg && pin_latched_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_interlock;
    !(lpr_reg && powerdown_control_reg);
  endproperty
  a_interlock: assert property (p_interlock) else $error("interlock");

  property p_ppd_stay;
    (mode_reg == MODE_PPD) && !ppd_wake && !rst_evt |=> mode_reg == MODE_PPD;
  endproperty
  a_ppd_stay: assert property (p_ppd_stay) else $error("ppd left");

  c_low_power_wait_mode: cover property (mode_reg == MODE_LOW_POWER_WAIT_MODE ##[1:20] mode_reg == MODE_LOW_POWER_RUN_MODE);
  c_ppd_wake: cover property (mode_reg == MODE_PPD ##1 powerdown_wake_flag_reg ##[1:50] !powerdown_wake_flag_reg);
  c_light_lp: cover property (mode_reg == MODE_LIGHT && from_lp_reg ##1 mode_reg == MODE_RUN);
  c_illegal: cover property (illegal_rst_o);

endmodule : low_power_mode_controller

// ==== inc/lpm_pkg.sv ====
// constants, types and register map of the low power mode controller
// assumes a 32-bit classic wishbone register bus and a 25 MHz system clock
package lpm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00; // power_mgmt_control_one
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h04; // power_mgmt_control_two
  localparam logic [7:0] OFS_SYS_OPT    = 8'h08; // system_option_one
  localparam logic [7:0] OFS_DBG_CTRL   = 8'h0c; // debug_status_control
  localparam logic [7:0] OFS_MODE_STAT  = 8'h10; // current mode, read only
  localparam int         ADDR_W         = 8;

  // field positions
  localparam int BIT_LOWVOLT_DETECT_ENABLE   = 0; // lowvolt_detect_enable
  localparam int BIT_LOWVOLT_DETECT_IN_STOP_ENABLE  = 1; // lowvolt_detect_in_stop_enable
  localparam int BIT_LPR    = 0; // low_power_run_request
  localparam int BIT_LOW_POWER_RUN_STATUS   = 1; // low_power_run_status, read only
  localparam int BIT_WUI    = 2; // regulator_wake_on_irq
  localparam int BIT_POWERDOWN_CONTROL   = 3; // powerdown_control
  localparam int BIT_POWERDOWN_WAKE_FLAG   = 4; // powerdown_wake_flag, read only
  localparam int BIT_POWERDOWN_ACKNOWLEDGE = 5; // powerdown_acknowledge, write one, reads zero
  localparam int BIT_STOP_INSTRUCTION_ENABLE  = 0; // stop_instruction_enable
  localparam int BIT_DEBUG_MODE_ENABLE  = 0; // debug_mode_enable

  // reset values
  localparam logic RST_STOP_INSTRUCTION_ENABLE = 1'b0;
  localparam logic RST_DEBUG_MODE_ENABLE = 1'b0;
  localparam logic RST_LOWVOLT_DETECT_ENABLE  = 1'b1;
  localparam logic RST_LOWVOLT_DETECT_IN_STOP_ENABLE = 1'b0;

  localparam int PIN_W = 8; // latched pin control width
  localparam int MODE_W = 6;

  // one-hot operating modes
  typedef enum logic [MODE_W-1:0] {
    MODE_RUN    = 6'h01,
    MODE_LOW_POWER_RUN_MODE  = 6'h02,
    MODE_WAIT   = 6'h04,
    MODE_LOW_POWER_WAIT_MODE = 6'h08,
    MODE_LIGHT  = 6'h10, // light_stop
    MODE_PPD    = 6'h20  // partial_powerdown_stop
  } mode_t;

  // regulator states driven out
  typedef enum logic [1:0] {
    REG_FULL    = 2'h0,
    REG_STANDBY = 2'h1,
    REG_PARTIAL = 2'h2
  } reg_state_t;

  // outcome of a stop instruction
  typedef enum logic [1:0] {
    SEL_ILLEGAL = 2'h0,
    SEL_LIGHT   = 2'h1,
    SEL_PPD     = 2'h2
  } stop_sel_t;

  // wake and debug events from the surroundings
  typedef struct packed {
    logic reset_pin_n; // reset pin level
    logic irq_pin_n;   // interrupt request pin level
    logic tod_irq;     // time_of_day_unit interrupt
    logic irq;         // any enabled interrupt pending
    logic bg_cmd;      // background command pulse
    logic mem_stat_cmd; // memory-access-with-status command pulse
  } wake_t;

  // clock enables driven out
  typedef struct packed {
    logic cpu;
    logic bus;
    logic debug;
  } clk_en_t;

endpackage : lpm_pkg

// ==== dv/core_model.sv ====
// stand-in for the processor core: issues wait and stop instructions
// assumes one system clock and the controller's cpu clock enable
`timescale 1ns/1ns
module core_model (
  input  wire logic clk_i,       // system clock
  input  wire logic cpu_en_i,    // processor clock running
  output logic      wait_exec_o, // pulse: wait executed
  output logic      stop_exec_o  // pulse: stop executed
);
  // idle until the bench asks for an instruction
  initial begin
    wait_exec_o = 1'b0;
    stop_exec_o = 1'b0;
  end
  // a halted core fetches nothing, so an instruction waits for its clock
  task automatic exec(input logic is_stop, input int slow);
    int n;
    n = 0;
    repeat (slow + 1) @(posedge clk_i);
    while (cpu_en_i !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    if (is_stop) stop_exec_o <= 1'b1;
    else wait_exec_o <= 1'b1;
    @(posedge clk_i);
    stop_exec_o <= 1'b0;
    wait_exec_o <= 1'b0;
  endtask
endmodule // core_model

// ==== dv/tb.sv ====
// bench for the low power mode controller: bus, core and wake stimulus
// assumes the core stand-in and the assertions inside the design
`timescale 1ns/1ns
module tb
  import lpm_pkg::*;
;
  localparam logic [5:0] IDLE = 6'h30, W_RST = 6'h10, W_IRQ = 6'h34, W_TOD = 6'h38;
  localparam logic [5:0] W_BG = 6'h32, W_MEM = 6'h31, P_IRQ = 6'h10, P_ILL = 6'h2c;
  localparam logic [5:0] P_RST = 6'h24, P_ERR = 6'h02, P_BG = 6'h01;
  localparam logic [5:0] WK[4] = '{W_BG, W_IRQ, W_RST, W_TOD};
  localparam logic [5:0] PX[4] = '{P_BG, P_IRQ, P_RST, P_RST};
  logic        clk_i, rst_n_i, wb_cyc, wb_stb, wb_we;
  logic [3:0]  wb_sel;
  logic [7:0]  wb_adr, pins_in, v0;
  logic [31:0] wb_wdat, seed = 32'hc7e6;
  wake_t       wake;
  wire         wb_ack, wait_x, stop_x, latched, disp;
  wire [31:0]  wb_rdat;
  wire [7:0]   pins_out;
  wire [5:0]   pulses, mode;
  wire clk_en_t    clk_en;
  wire reg_state_t regul;
  logic [5:0]  prev_mode, md_q[$], pl_q[$];
  logic [31:0] rd_q[$];
  int          fail_count, compares;

  low_power_mode_controller low_power_mode_controller_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_sel_i(wb_sel), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .wait_exec_i(wait_x), .stop_exec_i(stop_x), .wake_i(wake),
    .pin_ctrl_i(pins_in), .pin_ctrl_o(pins_out), .pin_latched_o(latched),
    .display_drive_o(disp), .clk_en_o(clk_en), .regulator_o(regul),
    .reset_vector_o(pulses[5]), .irq_vector_o(pulses[4]), .illegal_rst_o(pulses[3]),
    .module_rst_o(pulses[2]), .debug_err_o(pulses[1]), .debug_wake_o(pulses[0]),
    .mode_o(mode));
  core_model core_model_inst (.clk_i(clk_i), .cpu_en_i(clk_en.cpu), .wait_exec_o(wait_x),
    .stop_exec_o(stop_x));

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic note(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_data(string n, logic [31:0] e, logic [31:0] g);
    note(n, e, g);
  endtask
  task automatic chk_mode(logic [5:0] e, logic [5:0] g);
    note("mode", {26'h0, e}, {26'h0, g});
  endtask
  task automatic chk_pulse(logic [5:0] e, logic [5:0] g);
    note("pulses", {26'h0, e}, {26'h0, g});
  endtask
  task automatic give_verdict();
    fail_count += rd_q.size() + md_q.size() + pl_q.size();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // monitor: each result that appears takes the oldest note, extras show as x
  always @(posedge clk_i) begin
    if (rst_n_i === 1'b1) begin
      if (wb_ack === 1'b1 && wb_we === 1'b0)
        chk_data("read", rd_q.size() > 0 ? rd_q.pop_front() : 'x, wb_rdat);
      if (mode !== prev_mode) chk_mode(md_q.size() > 0 ? md_q.pop_front() : 'x, mode);
      if (pulses !== 6'h0) chk_pulse(pl_q.size() > 0 ? pl_q.pop_front() : 'x, pulses);
    end
    prev_mode = mode;
  end

  // one classic cycle; the gap edge at entry keeps cyc low between transfers
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    int n;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr} <= {2'b11, w, a};
    wb_wdat <= {24'h0, d} | (xs() & 32'hffffff00);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    {wb_cyc, wb_stb} <= 2'b00;
    if (wb_ack !== 1'b1) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h0);
  endtask
  task automatic wk(logic [5:0] v);
    @(posedge clk_i);
    wake <= v;
    @(posedge clk_i);
    wake <= IDLE;
  endtask
  task automatic ex(logic s);
    core_model_inst.exec(s, int'(xs() % 3));
  endtask
  task automatic xp(logic [5:0] m, logic [5:0] p);
    if (m != 6'h0) md_q.push_back(m);
    if (p != 6'h0) pl_q.push_back(p);
  endtask
  task automatic wm(logic [5:0] m);
    for (int n = 0; n < 20 && mode !== m; n++) @(posedge clk_i);
    if (mode !== m) begin
      fail_count++;
      give_verdict();
    end
  endtask
  task automatic st(logic [1:0] r, logic [2:0] c);
    chk_data("power", {27'h0, r, c}, {27'h0, regul, clk_en});
  endtask

  // main sequence
  initial begin
    {rst_n_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} = '0;
    wake = IDLE;
    pins_in = 8'h0;
    wb_sel = 4'hf;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_CTRL_ONE, {30'h0, RST_LOWVOLT_DETECT_IN_STOP_ENABLE, RST_LOWVOLT_DETECT_ENABLE});
    rd(OFS_CTRL_TWO, 32'h0);
    rd(OFS_SYS_OPT, {31'h0, RST_STOP_INSTRUCTION_ENABLE});
    rd(OFS_DBG_CTRL, {31'h0, RST_DEBUG_MODE_ENABLE});
    rd(OFS_MODE_STAT, {26'h0, MODE_RUN});
    rd(8'h14, 32'h0);
    xp(6'h0, P_ILL); ex(1'b1);
    wr(OFS_CTRL_TWO, 8'h08);
    wr(OFS_CTRL_TWO, 8'h09);
    rd(OFS_CTRL_TWO, 32'h08);
    wr(OFS_CTRL_TWO, 8'h00);
    // powerdown_control clear for low power run
    xp(MODE_LOW_POWER_RUN_MODE, 6'h0); wr(OFS_CTRL_TWO, 8'h01);
    wr(OFS_CTRL_TWO, 8'h09);
    rd(OFS_CTRL_TWO, 32'h03);
    xp(MODE_LOW_POWER_WAIT_MODE, 6'h0); ex(1'b0); wm(MODE_LOW_POWER_WAIT_MODE);
    st(REG_STANDBY, 3'b010);
    xp(MODE_LOW_POWER_RUN_MODE, P_IRQ); wk(W_IRQ); wm(MODE_LOW_POWER_RUN_MODE);
    wr(OFS_CTRL_TWO, 8'h05);
    xp(MODE_LOW_POWER_WAIT_MODE, 6'h0); ex(1'b0); wm(MODE_LOW_POWER_WAIT_MODE);
    xp(MODE_RUN, P_IRQ); wk(W_IRQ); wm(MODE_RUN);
    rd(OFS_CTRL_TWO, 32'h04);
    xp(MODE_LOW_POWER_RUN_MODE, 6'h0); wr(OFS_CTRL_TWO, 8'h01);
    xp(MODE_LOW_POWER_WAIT_MODE, 6'h0); ex(1'b0); wm(MODE_LOW_POWER_WAIT_MODE);
    xp(MODE_RUN, P_RST); wk(W_RST); wm(MODE_RUN);
    rd(OFS_CTRL_TWO, 32'h00);
    wr(OFS_SYS_OPT, 8'h01);
    xp(MODE_LOW_POWER_RUN_MODE, 6'h0); wr(OFS_CTRL_TWO, 8'h01);
    xp(MODE_LIGHT, 6'h0); ex(1'b1); wm(MODE_LIGHT);
    st(REG_STANDBY, 3'b000);
    rd(OFS_CTRL_TWO, 32'h03);
    xp(6'h0, P_ERR); wk(W_MEM);
    wk(W_BG);
    xp(MODE_LOW_POWER_RUN_MODE, P_IRQ); wk(W_IRQ); wm(MODE_LOW_POWER_RUN_MODE);
    xp(MODE_RUN, 6'h0); wr(OFS_CTRL_TWO, 8'h00);
    xp(MODE_LOW_POWER_RUN_MODE, 6'h0); wr(OFS_CTRL_TWO, 8'h05);
    xp(MODE_RUN, P_IRQ); wk(W_IRQ); wm(MODE_RUN);
    rd(OFS_CTRL_TWO, 32'h04);
    // selection table: debug, low volt in stop, light, powerdown
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL_ONE, {6'h0, i == 1, 1'b1});
      wr(OFS_CTRL_TWO, i == 2 ? 8'h00 : 8'h08);
      wr(OFS_DBG_CTRL, {7'h0, i == 0});
      wr(OFS_SYS_OPT, 8'h01);
      v0 = 8'(xs());
      pins_in <= v0;
      xp(i == 3 ? MODE_PPD : MODE_LIGHT, 6'h0); ex(1'b1); wm(i == 3 ? MODE_PPD : MODE_LIGHT);
      st(i == 3 ? REG_PARTIAL : i == 2 ? REG_STANDBY : REG_FULL, {2'b00, i == 0});
      if (i == 3) begin
        pins_in <= ~v0;
        wk(W_IRQ);
        chk_data("pads", {22'h0, 2'b11, v0}, {22'h0, disp, latched, pins_out});
      end
      xp(MODE_RUN, PX[i]); wk(WK[i]); wm(MODE_RUN);
      if (i == 3) begin
        rd(OFS_CTRL_TWO, 32'h18);
        chk_data("pads", {22'h0, 2'b11, v0}, {22'h0, disp, latched, pins_out});
        pins_in <= v0;
        wr(OFS_CTRL_TWO, 8'h28);
        rd(OFS_CTRL_TWO, 32'h08);
        chk_data("pads", {22'h0, 2'b10, v0}, {22'h0, disp, latched, pins_out});
      end
    end
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule // tb
